// File: hw/tpi_core.sv
`timescale 1ns/1ps
// Overview of operation
// RL1: in pilot mode, pickup asserts transmit, opening the loop contact.
// RL2: fault found inside overreach zone drops transmit, reclosing the loop.
// RL3: receive input is active low; deenergized loop blocks overreach trip.
// RL4: both ends reclosed and loop energized releases overreach tripping.
// RL5: loop open continuously 10 s raises alarm and blocks pilot supplement.
// RL6: first zone and other stages trip independent of pilot state.
// RL7: overreach trip waits a short settable delay.
// RL8: reverse interlock blocks overreach zone while downstream pickup received.
// RL9: reverse interlock block is stretched by the hold time after drop.
// RL10: reverse interlock supports blocking and release polarity.
// RL11: reverse fault within wait time inhibits transmit and zone release.
// RL12: transient inhibit lasts hold time after criterion resets.
// RL13: first-zone trip ends the transient hold at once.
// RL14: in permissive mode transient blocking inhibits transmit and receive.
// RL15: in blocking scheme transient blocking stretches the received block.
// RL16: stretch only when block was present at least the wait time.
// RL17: all delays count a fixed tick with settable terminal counts.
module tpi_core #(
  parameter int TICK_CYC = tpi_pkg::TICK_CYC
) (
  input  wire logic                mclk,
  input  wire logic                sys_rst,
  input  wire logic                ce,
  input  wire logic [31:0]         haddr,
  input  wire logic                hsel,
  input  wire logic [1:0]          htrans,
  input  wire logic                hwrite,
  input  wire logic [2:0]          hsize,
  input  wire logic [31:0]         hwdata,
  input  wire logic                hready,
  output logic [31:0]              hrdata,
  output logic                     hreadyout,
  output logic                     hresp,
  input  wire tpi_pkg::tpi_prot_t  prot,
  input  wire logic                tele_receive_in,
  output tpi_pkg::tpi_out_t        tout,
  output logic                     irq
);

  typedef struct packed {
    logic                       en;
    tpi_pkg::tpi_mode_t         mode;
    logic                       rel_pol;
    logic [tpi_pkg::EV_W-1:0]   sts;
    logic [tpi_pkg::EV_W-1:0]   msk;
    logic [15:0]                wait_tc;
    logic [15:0]                hold_tc;
    logic [15:0]                ozd_tc;
    logic [15:0]                fail_tc;
    logic [15:0]                tick_cnt;
    logic                       dp_wr;
    logic [7:0]                 dp_addr;
    logic [31:0]                rdata;
    logic [15:0]                fail_cnt;
    logic [15:0]                wait_cnt;
    tpi_pkg::tpi_tb_t           tb;
    logic [15:0]                tb_cnt;
    logic                       blk_q;
    logic [15:0]                blk_pres;
    logic [15:0]                blk_hold;
    logic [15:0]                ozd_cnt;
    logic [tpi_pkg::EV_W-1:0]   ev_q;
    tpi_pkg::tpi_out_t          out;
    logic                       irq;
  } tpi_state_t;

  tpi_state_t st;
  tpi_state_t next_st;
  logic       rx;
  logic       tick;
  logic       pil;
  logic       rvl;
  logic       bsch;
  logic       tb_inh;
  logic       window;
  logic       blk_raw;
  logic       blk_ext;
  logic       release_oz;
  logic       take;
  logic [tpi_pkg::EV_W-1:0] ev_now;
  logic [tpi_pkg::EV_W-1:0] w1c;

  // saturating tick counter step
  function automatic logic [15:0] tick_inc(input logic [15:0] v,
                                           input logic        en);
    return (en && v != 16'hffff) ? v + 16'h0001 : v;
  endfunction : tick_inc

  // register read mux
  function automatic logic [31:0] rd_mux(input tpi_state_t s,
                                         input logic [7:0] a,
                                         input logic [6:0] live);
    case (a)
      tpi_pkg::OFS_CTRL: rd_mux = {28'h0, s.rel_pol, s.mode, s.en};
      tpi_pkg::OFS_STS:  rd_mux = {28'h0, s.sts};
      tpi_pkg::OFS_MASK: rd_mux = {28'h0, s.msk};
      tpi_pkg::OFS_LIVE: rd_mux = {25'h0, live};
      tpi_pkg::OFS_WAIT: rd_mux = {16'h0, s.wait_tc};
      tpi_pkg::OFS_HOLD: rd_mux = {16'h0, s.hold_tc};
      tpi_pkg::OFS_OZD:  rd_mux = {16'h0, s.ozd_tc};
      tpi_pkg::OFS_FAIL: rd_mux = {16'h0, s.fail_tc};
      default:           rd_mux = 32'h0;
    endcase
  endfunction : rd_mux

  // receive pin comes from the loop, outside the clock domain
  tpi_sync u_rx_sync (
    .mclk    (mclk),
    .sys_rst (sys_rst),
    .ce      (ce),
    .d       (tele_receive_in),
    .q       (rx)
  );

  // decoded state shared by the next-state logic and the checks
  assign tick   = (st.tick_cnt == 16'(TICK_CYC - 1)); // RL17
  assign pil    = st.en && st.mode == tpi_pkg::TPI_PILOT;
  assign rvl    = st.en && st.mode == tpi_pkg::TPI_REVIL;
  assign bsch   = st.en && st.mode == tpi_pkg::TPI_BLOCK;
  assign tb_inh = st.tb != tpi_pkg::TB_IDLE; // RL12
  assign window = prot.pickup && st.wait_cnt < st.wait_tc; // RL11
  // release mode: series NC contacts, energized means no block
  assign blk_raw = rvl ? (rx ^ st.rel_pol) : (bsch & rx); // RL10
  assign blk_ext = blk_raw || st.blk_hold != 16'h0; // RL9 RL15
  // pilot: energized loop releases unless failed or transient-blocked
  always_comb begin
    if (pil) begin
      release_oz = rx && !st.out.alarm && !tb_inh; // RL3 RL4 RL5 RL14
    end else if (rvl || bsch) begin
      release_oz = !blk_ext; // RL8
    end else begin
      release_oz = 1'b0;
    end
  end
  assign take = hsel && hready && htrans[1] && hsize == 3'b010;
  assign ev_now = {st.out.stage_trip, tb_inh, st.out.oz_trip,
                   st.out.alarm};
  assign w1c = (st.dp_wr && st.dp_addr == tpi_pkg::OFS_STS)
             ? hwdata[tpi_pkg::EV_W-1:0] : '0;

  // one next-state process for the whole block
  always_comb begin
    next_st = st;
    // fixed timebase tick
    next_st.tick_cnt = tick ? 16'h0 : st.tick_cnt + 16'h0001; // RL17

    // bus slave: address phase captured, write lands in data phase
    next_st.dp_wr = take && hwrite;
    next_st.dp_addr = haddr[31:8] == 24'h0 ? haddr[7:0] : 8'hff;
    if (take && !hwrite) begin
      next_st.rdata = rd_mux(st, haddr[31:8] == 24'h0 ? haddr[7:0]
                             : 8'hff, {rx, tb_inh, blk_ext, release_oz,
                             st.out.alarm, st.out.send, st.out.oz_trip});
    end
    if (st.dp_wr) begin
      case (st.dp_addr)
        tpi_pkg::OFS_CTRL: begin
          next_st.en = hwdata[tpi_pkg::CTRL_EN];
          next_st.mode = tpi_pkg::tpi_mode_t'(
                         hwdata[tpi_pkg::CTRL_MODE +: 2]);
          next_st.rel_pol = hwdata[tpi_pkg::CTRL_POL];
        end
        tpi_pkg::OFS_MASK: next_st.msk = hwdata[tpi_pkg::EV_W-1:0];
        tpi_pkg::OFS_WAIT: next_st.wait_tc = hwdata[15:0];
        tpi_pkg::OFS_HOLD: next_st.hold_tc = hwdata[15:0];
        tpi_pkg::OFS_OZD:  next_st.ozd_tc = hwdata[15:0];
        tpi_pkg::OFS_FAIL: next_st.fail_tc = hwdata[15:0];
        default: next_st.en = st.en;
      endcase
    end

    // loop failure supervision: a pickup outside the overreach zone opens the loop briefly
    if (pil && !rx) begin
      next_st.fail_cnt = tick_inc(st.fail_cnt, tick); // RL5
    end else begin
      next_st.fail_cnt = 16'h0;
    end
    next_st.out.alarm = pil && !rx && st.fail_cnt >= st.fail_tc; // RL5

    // wait window runs from pickup
    next_st.wait_cnt = prot.pickup ? tick_inc(st.wait_cnt, tick)
                                   : 16'h0; // RL11

    // transient blocking for the permissive pilot scheme
    case (st.tb)
      tpi_pkg::TB_IDLE: begin
        next_st.tb_cnt = 16'h0;
        if (pil && prot.rev_fault && window) begin
          next_st.tb = tpi_pkg::TB_ACT; // RL11
        end
      end
      tpi_pkg::TB_ACT: begin
        if (!pil) begin
          next_st.tb = tpi_pkg::TB_IDLE;
        end else if (!prot.rev_fault) begin
          next_st.tb = prot.z1_trip ? tpi_pkg::TB_IDLE
                                    : tpi_pkg::TB_HOLD; // RL12 RL13
        end
      end
      tpi_pkg::TB_HOLD: begin
        next_st.tb_cnt = tick_inc(st.tb_cnt, tick); // RL12
        if (!pil || prot.z1_trip) begin
          next_st.tb = tpi_pkg::TB_IDLE; // RL13
        end else if (prot.rev_fault && window) begin
          next_st.tb = tpi_pkg::TB_ACT;
        end else if (st.tb_cnt >= st.hold_tc) begin
          next_st.tb = tpi_pkg::TB_IDLE; // RL12
        end
      end
      default: next_st.tb = tpi_pkg::TB_IDLE;
    endcase

    // received block: presence time and stretch after it drops
    next_st.blk_q = blk_raw;
    next_st.blk_pres = blk_raw ? tick_inc(st.blk_pres, tick) : 16'h0;
    if (blk_raw) begin
      next_st.blk_hold = 16'h0;
    end else if (st.blk_q && (rvl || st.blk_pres >= st.wait_tc)) begin
      next_st.blk_hold = st.hold_tc; // RL9 RL15 RL16
    end else if (st.blk_hold != 16'h0 && tick) begin
      next_st.blk_hold = st.blk_hold - 16'h0001;
    end

    // pilot transmit: open on pickup, reclose once fault is inside zone
    next_st.out.send = pil && prot.pickup
                    && (!prot.fwd_ovr || tb_inh); // RL1 RL2 RL14

    // overreach zone delay, restarted whenever release is lost
    if (prot.fwd_ovr && release_oz) begin
      next_st.ozd_cnt = tick_inc(st.ozd_cnt, tick); // RL7
    end else begin
      next_st.ozd_cnt = 16'h0;
    end
    next_st.out.oz_trip = prot.fwd_ovr && release_oz
                       && st.ozd_cnt >= st.ozd_tc; // RL4 RL7 RL8
    // graded stages never depend on the pilot link
    next_st.out.stage_trip = prot.z1_trip || prot.stage_trip; // RL6

    // sticky events, a new event wins over a write-one clear
    next_st.ev_q = ev_now;
    next_st.sts = (st.sts & ~w1c) | (ev_now & ~st.ev_q);
    next_st.irq = |(next_st.sts & next_st.msk);
  end

  // single state register; ce low freezes everything
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      st <= '0;
      st.wait_tc <= tpi_pkg::WAIT_RST;
      st.hold_tc <= tpi_pkg::HOLD_RST;
      st.ozd_tc <= tpi_pkg::OZD_RST;
      st.fail_tc <= tpi_pkg::FAIL_RST;
    end else if (ce) begin
      st <= next_st;
    end
  end

  // zero wait states while running; a frozen block stalls the bus
  assign hreadyout = ce;
  assign hresp = 1'b0;
  assign hrdata = st.rdata;
  assign tout = st.out;
  assign irq = st.irq;

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (sys_rst);

  sequence pilot_open_s;
    ce && pil && prot.pickup && !prot.fwd_ovr;
  endsequence

  sequence pilot_close_s;
    ce && pil && prot.pickup && prot.fwd_ovr && !tb_inh;
  endsequence

  send_on_pickup_a: assert property (pilot_open_s |=> tout.send) // RL1
    else $error("transmit not raised on pickup");
  send_reclose_a: assert property (pilot_close_s |=> !tout.send) // RL2
    else $error("transmit not dropped for fault in zone");
  rx_block_a: assert property (ce && pil && !rx |=> !tout.oz_trip) // RL3
    else $error("overreach trip with loop deenergized");
  loop_release_a: assert property (ce && pil && rx && !tout.alarm
    && !tb_inh && prot.fwd_ovr && st.ozd_cnt >= st.ozd_tc
    |=> tout.oz_trip) // RL4
    else $error("overreach trip not released on energized loop");
  fail_alarm_a: assert property ($rose(tout.alarm) |->
    $past(st.fail_cnt) >= $past(st.fail_tc) && !$past(rx)) // RL5
    else $error("alarm before loop failure delay");
  stage_indep_a: assert property (ce |=> tout.stage_trip ==
    $past(prot.z1_trip || prot.stage_trip)) // RL6
    else $error("graded stage trip altered");
  oz_delay_a: assert property ($rose(tout.oz_trip) |->
    $past(st.ozd_cnt) >= $past(st.ozd_tc)) // RL7
    else $error("overreach trip before its delay");
  revil_block_a: assert property (ce && rvl && blk_raw
    |=> !tout.oz_trip) // RL8
    else $error("overreach trip during reverse interlock block");
  revil_hold_a: assert property (ce && rvl && st.blk_q && !blk_raw
    |=> st.blk_hold == $past(st.hold_tc)) // RL9
    else $error("block not stretched by hold time");
  tb_enter_a: assert property (ce && pil && st.tb == tpi_pkg::TB_IDLE
    && prot.rev_fault && window |=> st.tb == tpi_pkg::TB_ACT) // RL11
    else $error("transient block not entered");
  tb_z1_a: assert property (ce && st.tb == tpi_pkg::TB_HOLD
    && prot.z1_trip |=> st.tb == tpi_pkg::TB_IDLE) // RL13
    else $error("hold not ended by first zone trip");
  stretch_min_a: assert property (ce && bsch && st.blk_q && !blk_raw
    && st.blk_pres < st.wait_tc |=> st.blk_hold == 16'h0) // RL16
    else $error("short block stretched");

endmodule : tpi_core

// File: include/tpi_pkg.sv
package tpi_pkg;

  // clock and internal timebase
  localparam int CLK_NS   = 25;              // mclk period, 40 MHz
  localparam int TICK_US  = 1000;            // one timebase tick, in us
  localparam int TICK_CYC = TICK_US * 1000 / CLK_NS;
  localparam int FAIL_S   = 10;              // loop failure alarm delay, s
  localparam int TMR_W    = 16;

  // reset values of the settings, in ticks
  localparam logic [15:0] WAIT_RST = 16'h0014;
  localparam logic [15:0] HOLD_RST = 16'h0064;
  localparam logic [15:0] OZD_RST  = 16'h000a;
  localparam logic [15:0] FAIL_RST = 16'(FAIL_S * 1000000 / TICK_US);

  // register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STS  = 8'h04;
  localparam logic [7:0] OFS_MASK = 8'h08;
  localparam logic [7:0] OFS_LIVE = 8'h0c;
  localparam logic [7:0] OFS_WAIT = 8'h10;
  localparam logic [7:0] OFS_HOLD = 8'h14;
  localparam logic [7:0] OFS_OZD  = 8'h18;
  localparam logic [7:0] OFS_FAIL = 8'h1c;

  // control register fields
  localparam int CTRL_EN   = 0;
  localparam int CTRL_MODE = 1;              // two bits, 2:1
  localparam int CTRL_POL  = 3;

  // event bits of status and mask
  localparam int EV_FAIL  = 0;
  localparam int EV_OZ    = 1;
  localparam int EV_TB    = 2;
  localparam int EV_STAGE = 3;
  localparam int EV_W     = 4;

  typedef enum logic [1:0] {
    TPI_OFF   = 2'b00,
    TPI_PILOT = 2'b01,
    TPI_REVIL = 2'b10,
    TPI_BLOCK = 2'b11
  } tpi_mode_t;

  typedef enum logic [1:0] {
    TB_IDLE = 2'b00,
    TB_ACT  = 2'b01,
    TB_HOLD = 2'b10
  } tpi_tb_t;

  // decisions of the distance function, same clock domain
  typedef struct packed {
    logic pickup;
    logic fwd_ovr;
    logic rev_fault;
    logic z1_trip;
    logic stage_trip;
  } tpi_prot_t;

  typedef struct packed {
    logic send;
    logic oz_trip;
    logic stage_trip;
    logic alarm;
  } tpi_out_t;

endpackage : tpi_pkg

// File: hw/tpi_sync.sv
`timescale 1ns/1ps
module tpi_sync (
  input  wire logic mclk,
  input  wire logic sys_rst,
  input  wire logic ce,
  input  wire logic d,
  output logic      q
);

  typedef struct packed {
    logic [2:0] s;
    logic       q;
  } tpi_sync_t;

  tpi_sync_t st;
  tpi_sync_t next_st;

  // three stages; output follows only when stages two and three agree
  always_comb begin
    next_st = st;
    next_st.s = {st.s[1:0], d};
    if (st.s[1] == st.s[2]) begin
      next_st.q = st.s[2];
    end
  end

  // loop reads deenergized after reset, the safe blocking state
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      st <= '0;
    end else if (ce) begin
      st <= next_st;
    end
  end

  assign q = st.q;

endmodule : tpi_sync

// File: testbench/tpi_remote_end.sv
`timescale 1ns/1ps
// far side: remote relay on the pilot loop, or downstream feeder contacts
module tpi_remote_end (
  input  wire logic local_send,
  input  wire logic far_send,
  input  wire logic wire_cut,
  input  wire logic loop_mode,
  input  wire logic nc_release,
  input  wire logic feeder_pick,
  output logic      rx
);
  // loop carries current only with both contacts closed and wires intact;
  // feeder side: parallel NO contacts close on pickup, series NC ones open
  always_comb begin
    if (loop_mode) begin
      rx = !local_send && !far_send && !wire_cut;
    end else begin
      rx = nc_release ? !feeder_pick : feeder_pick;
    end
  end
endmodule : tpi_remote_end

// File: testbench/tpi_core_test.sv
`timescale 1ns/1ps
module tpi_core_test;
  localparam int TK   = 4;
  localparam int OZD  = 10 * TK;
  localparam int HOLD = 100 * TK;
  localparam int FL   = 32 * TK;

  logic               mclk, sys_rst, ce, hsel, hwrite, hresp;
  logic               hreadyout, irq, rx, far_send, wire_cut;
  logic               loop_mode, nc_release, fpick;
  logic [31:0]        haddr, hwdata, hrdata, rd;
  logic [1:0]         htrans;
  logic [2:0]         hsize;
  tpi_pkg::tpi_prot_t prot;
  tpi_pkg::tpi_out_t  tout;
  int                 err_count, n_tests;

  tpi_core #(.TICK_CYC(TK)) i_tpi_core (
    .mclk(mclk), .sys_rst(sys_rst), .ce(ce), .haddr(haddr), .hsel(hsel),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .prot(prot), .tele_receive_in(rx), .tout(tout),
    .irq(irq)
  );

  tpi_remote_end i_tpi_remote_end (
    .local_send(tout.send), .far_send(far_send), .wire_cut(wire_cut),
    .loop_mode(loop_mode), .nc_release(nc_release), .feeder_pick(fpick),
    .rx(rx)
  );

  // 40 MHz clock
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  task automatic give_verdict();
    if (err_count == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : give_verdict

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      err_count++;
      $display("mismatch %s exp %h got %h", nm, e, g);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask : cyc

  // single word transfer; waits on hready, assumes no latency
  task automatic bus(input logic [7:0] a, input logic w,
                     input logic [31:0] wd);
    haddr  <= {24'h000000, a};
    hwrite <= w;
    htrans <= 2'h2;
    @(posedge mclk);
    while (hreadyout !== 1'b1) @(posedge mclk);
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge mclk);
    while (hreadyout !== 1'b1) @(posedge mclk);
    rd = hrdata;
    chk("hresp", 32'h0, {31'h0, hresp});
  endtask : bus

  // output bit b must not reach v before lo cycles, and must by hi;
  // lo equal to hi means it must never get there in that span
  task automatic span(input int b, input logic v, input int lo,
                      input int hi, input string nm);
    int k;
    k = 0;
    while (k < hi && tout[b] !== v) begin
      @(posedge mclk);
      k++;
    end
    chk(nm, 32'h1, {31'h0, (k >= lo) && (k < hi || lo == hi)});
  endtask : span

  task automatic t_reset();
    logic [7:0]  a [6];
    logic [31:0] e [6];
    a = '{tpi_pkg::OFS_CTRL, tpi_pkg::OFS_WAIT, tpi_pkg::OFS_HOLD,
          tpi_pkg::OFS_OZD, tpi_pkg::OFS_FAIL, 8'h20};
    e = '{32'h0, 32'h14, 32'h64, 32'h0a, 32'h2710, 32'h0};
    chk("tout", 32'h0, {28'h0, tout});
    for (int i = 0; i < 6; i++) begin
      bus(a[i], 1'b0, 32'h0);
      chk("reg", e[i], rd);
    end
  endtask : t_reset

  task automatic t_pilot();
    bus(tpi_pkg::OFS_MASK, 1'b1, 32'h2);
    bus(tpi_pkg::OFS_CTRL, 1'b1, 32'h3);
    cyc(8);
    prot <= 5'h10;
    span(3, 1'b1, 0, 3, "send up");
    far_send <= 1'b1;
    prot     <= 5'h18;
    span(3, 1'b0, 0, 3, "send down");
    span(2, 1'b1, 200, 200, "oz blocked");
    far_send <= 1'b0;
    span(2, 1'b1, OZD - 2 * TK, OZD + 6 * TK, "oz release");
    cyc(2);
    chk("irq", 32'h1, {31'h0, irq});
    bus(tpi_pkg::OFS_STS, 1'b0, 32'h0);
    chk("status", 32'h2, rd);
    bus(tpi_pkg::OFS_STS, 1'b1, 32'h2);
    bus(tpi_pkg::OFS_STS, 1'b0, 32'h0);
    chk("status", 32'h0, rd);
    chk("irq", 32'h0, {31'h0, irq});
    prot <= 5'h00;
    cyc(20);
  endtask : t_pilot

  // pilot wires cut: alarm late, masked from irq, stages unaffected
  task automatic t_alarm();
    bus(tpi_pkg::OFS_MASK, 1'b1, 32'h0);
    bus(tpi_pkg::OFS_FAIL, 1'b1, 32'h20);
    wire_cut <= 1'b1;
    span(0, 1'b1, FL - 2 * TK, FL + 6 * TK, "alarm");
    prot <= 5'h01;
    span(1, 1'b1, 0, 3, "stage");
    bus(tpi_pkg::OFS_STS, 1'b0, 32'h0);
    chk("status", 32'h9, rd);
    chk("irq", 32'h0, {31'h0, irq});
    bus(tpi_pkg::OFS_STS, 1'b1, 32'h9);
    wire_cut <= 1'b0;
    prot     <= 5'h00;
    span(0, 1'b0, 0, 12, "alarm off");
  endtask : t_alarm

  task automatic t_trans();
    prot <= 5'h14;
    cyc(10);
    bus(tpi_pkg::OFS_LIVE, 1'b0, 32'h0);
    chk("tb live", 32'h1, {31'h0, rd[5]});
    prot <= 5'h18;
    span(3, 1'b0, HOLD - 2 * TK, HOLD + 6 * TK, "tb hold");
    prot <= 5'h00;
    cyc(20);
    prot <= 5'h14;
    cyc(10);
    // let the criterion reset first so the first zone trip meets the hold
    prot <= 5'h18;
    cyc(8);
    prot <= 5'h1a;
    span(3, 1'b0, 0, 8, "z1 ends hold");
    bus(tpi_pkg::OFS_STS, 1'b0, 32'h0);
    chk("tb event", 32'h1, {31'h0, rd[2]});
    prot <= 5'h00;
    cyc(20);
  endtask : t_trans

  // both contact polarities of the feeder interlock
  task automatic t_revil();
    for (int p = 0; p < 2; p++) begin
      loop_mode  <= 1'b0;
      nc_release <= p[0];
      fpick      <= 1'b1;
      bus(tpi_pkg::OFS_CTRL, 1'b1, {28'h0, p[0], 3'h5});
      prot <= 5'h18;
      span(2, 1'b1, 200, 200, "ri block");
      fpick <= 1'b0;
      span(2, 1'b1, HOLD - 2 * TK, HOLD + OZD + 6 * TK, "ri hold");
      prot <= 5'h00;
      cyc(20);
    end
  endtask : t_revil

  task automatic t_block();
    nc_release <= 1'b0;
    bus(tpi_pkg::OFS_CTRL, 1'b1, 32'h7);
    fpick <= 1'b1;
    prot  <= 5'h18;
    cyc(20);
    fpick <= 1'b0;
    span(2, 1'b1, 0, OZD + 6 * TK, "short block");
    prot <= 5'h00;
    cyc(20);
    fpick <= 1'b1;
    prot  <= 5'h18;
    span(2, 1'b1, 200, 200, "block held");
    fpick <= 1'b0;
    span(2, 1'b1, HOLD - 2 * TK, HOLD + OZD + 6 * TK, "long block");
  endtask : t_block

  // main sequence; hsel, hsize and ce stay fixed
  initial begin
    err_count = 0;
    n_tests   = 0;
    sys_rst   <= 1'b1;
    ce        <= 1'b1;
    hsel      <= 1'b1;
    hsize     <= 3'h2;
    hwrite    <= 1'b0;
    htrans    <= 2'h0;
    haddr     <= 32'h0;
    hwdata    <= 32'h0;
    prot      <= 5'h00;
    far_send  <= 1'b0;
    wire_cut  <= 1'b0;
    loop_mode <= 1'b1;
    nc_release <= 1'b0;
    fpick     <= 1'b0;
    repeat (3) @(posedge mclk);
    sys_rst <= 1'b0;
    t_reset();
    t_pilot();
    t_alarm();
    t_trans();
    t_revil();
    t_block();
    give_verdict();
  end

  // a hang ends the run well after the roughly 3000 cycles needed
  initial begin
    repeat (20000) @(posedge mclk);
    err_count++;
    give_verdict();
  end
endmodule : tpi_core_test
